// file: rtl/flash_adc_pkg.sv
// Shared constants for the flash converter pipeline and its capture end
package flash_adc_pkg;
  localparam int COMP_COUNT = 63;
  localparam int CODE_BITS = 6;
  localparam int LOW_BITS = 5;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLING_DELAY_NS = 5;
  localparam int SAMPLING_DELAY_CYC =
    (SAMPLING_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_MIN_NS = 3;
  localparam int STROBE_HIGH_MIN_NS = 5;
  localparam int STROBE_LOW_CYC =
    (STROBE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC =
    (STROBE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;
  localparam logic [5:0] CODE_TOP = 6'h00;
  localparam logic [5:0] CODE_BOTTOM = 6'h3F;
endpackage

// file: rtl/flash_adc_if.sv
// Link between converter end and capture end
`timescale 1ns/1ns
`default_nettype none
interface flash_adc_if;
  logic strobe_p;
  logic strobe_n;
  logic msb_out;
  logic msb_n_out;
  logic [4:0] lower_code_bits;
  modport sample_strobe (input strobe_p, input strobe_n, output msb_out,
    output msb_n_out, output lower_code_bits);
  modport capt (output strobe_p, output strobe_n, input msb_out,
    input msb_n_out, input lower_code_bits);
endinterface
`default_nettype wire

// file: rtl/word_fifo.sv
// Small valid/ready FIFO for captured words
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Wrap-bit pointers only work for a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
    $error("word_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;
  // Full when pointers differ only in wrap bit
  assign in_ready_out = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
    (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid_out = (wr_ptr_reg != rd_ptr_reg);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_reg[AW-1:0]];
  // Storage has no reset; only pointers matter
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  // Pointer update
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/flash_adc_capture.sv
// Capture end: makes the strobe pair and latches converter words
`timescale 1ns/1ns
`default_nettype none
module flash_adc_capture #(
  parameter int LOW_CYC = flash_adc_pkg::STROBE_LOW_CYC,
  parameter int HIGH_CYC = flash_adc_pkg::STROBE_HIGH_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic twos_comp_in,
  flash_adc_if.capt link,
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [5:0] word_data_out,
  output logic overflow_out
);
  // Width counter is eight bits, so longer phases cannot be timed
  if (LOW_CYC < flash_adc_pkg::STROBE_LOW_CYC ||
      HIGH_CYC < flash_adc_pkg::STROBE_HIGH_CYC ||
      LOW_CYC > 256 || HIGH_CYC > 256) begin
    $error("flash_adc_capture: strobe widths out of range");
  end
  logic strobe_reg;
  logic [7:0] width_cnt_reg;
  logic [1:0] fill_reg;
  logic [5:0] cap_word_reg;
  logic cap_valid_reg;
  logic fifo_ready;
  logic [5:0] sample_word;
  logic [5:0] m1_reg, m2_reg;
  logic rise;
  ////////////////////////////////////////////////////////////////////////
  // Strobe divider: low then high, never faster than one cycle each
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_reg <= 1'b0;
      width_cnt_reg <= 8'h00;
    end else if (!run_in && !strobe_reg) begin
      width_cnt_reg <= 8'h00;
    end else if (!strobe_reg && width_cnt_reg >= 8'(LOW_CYC - 1)) begin
      strobe_reg <= 1'b1;
      width_cnt_reg <= 8'h00;
    end else if (strobe_reg && width_cnt_reg >= 8'(HIGH_CYC - 1)) begin
      strobe_reg <= 1'b0;
      width_cnt_reg <= 8'h00;
    end else begin
      width_cnt_reg <= width_cnt_reg + 8'h01;
    end
  end
  // Both strobe lines always driven as a true/complement pair
  assign link.strobe_p = strobe_reg;
  assign link.strobe_n = ~strobe_reg;
  assign rise = run_in && !strobe_reg &&
    width_cnt_reg >= 8'(LOW_CYC - 1);
  // Swap of the MSB pair selects offset two's complement
  assign sample_word = {twos_comp_in ? link.msb_n_out : link.msb_out,
    link.lower_code_bits};
  ////////////////////////////////////////////////////////////////////////
  // Converter lines come from another part: two flops before use
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m1_reg <= 6'h00;
      m2_reg <= 6'h00;
    end else begin
      m1_reg <= sample_word;
      m2_reg <= m1_reg;
    end
  end
  // Take the previous result at each strobe rising edge; skip the
  // first three edges since the pipeline holds nothing valid yet
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_reg <= 2'h0;
      cap_word_reg <= 6'h00;
      cap_valid_reg <= 1'b0;
    end else begin
      cap_valid_reg <= 1'b0;
      if (rise) begin
        if (fill_reg != 2'h3) fill_reg <= fill_reg + 2'h1;
        if (fill_reg == 2'h3) begin
          cap_word_reg <= m2_reg;
          cap_valid_reg <= 1'b1;
        end
      end
    end
  end
  // Dropped word when downstream stalls and the FIFO is full
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) overflow_out <= 1'b0;
    else if (cap_valid_reg && !fifo_ready) overflow_out <= 1'b1;
  end
  word_fifo #(.WIDTH(6), .DEPTH(flash_adc_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(cap_valid_reg),
    .in_ready_out(fifo_ready),
    .in_data_in(cap_word_reg),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(word_data_out)
  );
endmodule
`default_nettype wire

// file: rtl/flash_adc_sample_strobe.sv
// Converter end: thermometer latch, encoder and output register
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Latch comparators shortly after strobe rise
// - Encode latched pattern on strobe fall
// - Load output on following strobe rise
// - Output holds old value after rise
// - Capture takes previous result at rise
// - Sample N read while N+2 taken
// - In-span input gives code 0 to 63
// - Overrange saturates to matching full scale
// - MSB as true/complement pair, rest single
// - Swapping MSB pair gives two's complement
// - Strobe supplied as complementary pair
// - Strobe low at least 3 ns
// - Strobe high at least 5 ns
// - Comparators form thermometer; count to binary
// - Strobe at most 100 MHz
module flash_adc_sample_strobe (
  input wire logic ref_clk_in,
  input wire logic [62:0] comparator_in,
  flash_adc_if.sample_strobe link
);
  logic s1_reg, s2_reg, s3_reg;
  logic [62:0] c1_reg, c2_reg;
  logic [62:0] therm_reg;
  logic [5:0] code_reg;
  logic [5:0] out_reg;
  logic [flash_adc_pkg::SAMPLING_DELAY_CYC:0] rise_dly_reg;
  logic rise;
  logic fall;
  // Count of comparators that are on, bottom code at top reference.
  // A bubble in the pattern is absorbed by counting, not by edge search.
  function automatic logic [5:0] therm_to_code(input logic [62:0] t);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < flash_adc_pkg::COMP_COUNT; i++) begin
      if (t[i]) n = n + 6'h01;
    end
    return n;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Strobe and comparators arrive from outside; two flops each.
  // No reset: state is undefined until two strobe cycles pass.
  always_ff @(posedge ref_clk_in) begin
    s1_reg <= link.strobe_p & ~link.strobe_n;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    c1_reg <= comparator_in;
    c2_reg <= c1_reg;
  end
  assign rise = s2_reg && !s3_reg;
  assign fall = !s2_reg && s3_reg;
  // Delay line so sampling lands a fixed time after the rise
  always_ff @(posedge ref_clk_in) begin
    rise_dly_reg <= {rise_dly_reg[flash_adc_pkg::SAMPLING_DELAY_CYC-1:0],
      rise};
  end
  // Latch thermometer pattern after the sampling delay
  always_ff @(posedge ref_clk_in) begin
    if (rise_dly_reg[flash_adc_pkg::SAMPLING_DELAY_CYC-1])
      therm_reg <= c2_reg;
  end
  // Encode on the falling edge
  always_ff @(posedge ref_clk_in) begin
    if (fall) code_reg <= therm_to_code(therm_reg);
  end
  // Output register changes only at the rise, so the old word stands
  // through the whole low phase and the rise cycle itself
  always_ff @(posedge ref_clk_in) begin
    if (rise) out_reg <= code_reg;
  end
  assign link.msb_out = out_reg[5];
  assign link.msb_n_out = ~out_reg[5];
  assign link.lower_code_bits = out_reg[4:0];
endmodule
`default_nettype wire

// file: bench/flash_adc_checker.sv
// Concurrent checks on the link between converter and capture ends
`timescale 1ns/1ns
`default_nettype none
module flash_adc_checker #(
  parameter int LOW_CYC = 1,
  parameter int HIGH_CYC = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic strobe_p,
  input wire logic strobe_n,
  input wire logic msb_out,
  input wire logic msb_n_out,
  input wire logic [4:0] lower_code_bits
);
  logic prev_reg;
  logic [7:0] len_reg;
  logic [2:0] rises_reg;
  logic [4:0] since_reg;
  logic rise;
  logic ready;
  logic [5:0] word;
  assign rise = strobe_p && !prev_reg;
  assign ready = rises_reg == 3'h4;
  assign word = {msb_out, lower_code_bits};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////
  // Level run length and rise count; words are junk before four rises
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= 1'b0;
      len_reg <= 8'h00;
      rises_reg <= 3'h0;
    end else begin
      prev_reg <= strobe_p;
      len_reg <= (strobe_p != prev_reg) ? 8'h01
        : len_reg + 8'(len_reg != 8'hFF);
      if (rise && !ready) begin
        rises_reg <= rises_reg + 3'h1;
      end
    end
  end
  // No reset here: the converter end keeps its pipeline through one
  always_ff @(posedge ref_clk_in) begin
    since_reg <= rise ? 5'h00 : since_reg + 5'(since_reg != 5'h1F);
  end
  //////////////////////////////////////////////////////////////////////
  AST_STROBE_PAIR: assert property (strobe_n == !strobe_p)
    else $error("strobe pair not complementary");
  AST_RESET_IDLE: assert property ($rose(rst_n_in) |-> !strobe_p)
    else $error("strobe not idle after reset");
  AST_LOW_WIDTH: assert property (
    rise && rises_reg != 3'h0 |-> len_reg >= LOW_CYC)
    else $error("strobe low too short");
  AST_HIGH_WIDTH: assert property (
    !strobe_p && prev_reg && rises_reg != 3'h0 |-> len_reg >= HIGH_CYC)
    else $error("strobe high too short");
  AST_PERIOD: assert property (
    rise && rises_reg != 3'h0 |-> since_reg >= LOW_CYC + HIGH_CYC - 1)
    else $error("strobe period too short");
  AST_MSB_PAIR: assert property (ready |-> msb_n_out == !msb_out)
    else $error("msb pair not complementary");
  AST_OUT_HOLD: assert property (ready && rise |=> $stable(word))
    else $error("output changed right after rise");
  AST_OUT_LOAD: assert property (
    ready && $changed(word) |-> since_reg inside {[5'h01:5'h05]})
    else $error("output changed away from a rise");
endmodule
`default_nettype wire

// file: bench/flash_adc_convert_pipeline_bench.sv
// Self-checking bench: converter and capture ends joined by the link
`timescale 1ns/1ns
`default_nettype none
module flash_adc_convert_pipeline_bench;
  // Slow strobe so words are well apart in time
  localparam int STROBE_CYC = 8;
  logic ref_clk_in;
  logic rst_n_in;
  logic run_in;
  logic twos_comp_in;
  logic word_ready_in;
  logic [62:0] comparator_in;
  logic word_valid_out;
  logic [5:0] word_data_out;
  logic overflow_out;
  logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3E, 6'h3F};
  int n_errors = 0;
  int n_checks = 0;
  flash_adc_if flash_adc_if_inst ();
  flash_adc_sample_strobe flash_adc_sample_strobe_inst (.ref_clk_in(ref_clk_in),
    .comparator_in(comparator_in), .link(flash_adc_if_inst));
  flash_adc_capture #(.LOW_CYC(STROBE_CYC), .HIGH_CYC(STROBE_CYC))
  flash_adc_capture_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .run_in(run_in), .twos_comp_in(twos_comp_in), .link(flash_adc_if_inst),
    .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
    .word_data_out(word_data_out), .overflow_out(overflow_out));
  flash_adc_checker #(.LOW_CYC(STROBE_CYC), .HIGH_CYC(STROBE_CYC))
  flash_adc_checker_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .strobe_p(flash_adc_if_inst.strobe_p),
    .strobe_n(flash_adc_if_inst.strobe_n),
    .msb_out(flash_adc_if_inst.msb_out),
    .msb_n_out(flash_adc_if_inst.msb_n_out),
    .lower_code_bits(flash_adc_if_inst.lower_code_bits));
  //////////////////////////////////////////////////////////////////////
  // Comparators below the level are on
  function automatic logic [62:0] therm(input logic [5:0] k);
    return (63'h1 << k) - 63'h1;
  endfunction
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [5:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready rises at a falling edge, data is taken before the accepting edge
  task automatic get_word(output logic [5:0] w);
    int i;
    word_ready_in = 1'b1;
    for (i = 0; i < 100 && word_valid_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    if (i == 100) begin
      n_errors++;
      report_and_stop();
    end
    w = word_data_out;
    @(negedge ref_clk_in);
    word_ready_in = 1'b0;
    @(negedge ref_clk_in);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    logic [5:0] w;
    int i;
    rst_n_in = 1'b0;
    run_in = 1'b0;
    twos_comp_in = 1'b0;
    word_ready_in = 1'b0;
    comparator_in = 63'h0;
    // Twenty-one full clock cycles of reset before release
    repeat (21) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    check("idle", {2'h0, flash_adc_if_inst.strobe_p,
      flash_adc_if_inst.strobe_n, word_valid_out, overflow_out}, 6'h04);
    run_in = 1'b1;
    // Code boundaries in both formats; seven reads flush the pipeline
    for (int m = 0; m < 2; m++) begin
      twos_comp_in = m[0];
      foreach (codes[c]) begin
        comparator_in = therm(codes[c]);
        repeat (7) get_word(w);
        check("code", w, codes[c] ^ {m[0], 5'h00});
      end
    end
    // Reader stalls until the buffer refuses, then drains it dry
    twos_comp_in = 1'b0;
    comparator_in = therm(6'h2A);
    repeat (7) get_word(w);
    check("overflow", {5'h00, overflow_out}, 6'h00);
    for (i = 0; i < 300 && overflow_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    check("overflow", {5'h00, overflow_out}, 6'h01);
    if (i == 300) report_and_stop();
    run_in = 1'b0;
    repeat (60) @(negedge ref_clk_in);
    for (i = 0; i < 4; i++) begin
      get_word(w);
      check("stored", w, 6'h2A);
    end
    check("empty", {5'h00, word_valid_out}, 6'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
